/* File: logic/secondary_irq.sv */
// Secondary interrupt latch and mask block: groups 1 and 4, Avalon-MM slave with waitrequest.
// Assumes event levels come from other clock domains; one level interrupt line to the host.
//
// Contract
// RL1 - The power-button status bit 12 of group 1 sets on both edges of the button event.
// RL2 - Writing one to a status bit clears it, writing zero leaves it alone.
// RL3 - A set mask bit keeps its event off the primary interrupt.
// RL4 - Status bits latch and read back whatever the mask holds.
// RL5 - Mask 0 lets an event through, mask 1 blocks it.
// RL6 - All mask bits leave reset at 1.
// RL7 - The timeout status bit 11 of group 1 sets on a rising timeout and feeds its primary.
// RL8 - The data-ready status bit 8 of group 1 sets on a rising conversion-done and feeds its primary.
// RL9 - Comparator bits 7:4 of group 1 trigger in the direction chosen by their greater-than setting.
// RL10 - The supply-low status bit 15 of group 1 sets on a rising low condition and feeds its primary.
// RL11 - Periodic bit 3 and alarm bit 2 of group 1 set on rising edges and feed the clock primary.
// RL12 - Crystal start failure sets bit 7 of group 4 on a rising edge, masked by bit 7 of mask 4.
// RL13 - Crystal tamper sets bit 6 of group 4 on both edges.
// RL14 - Crystal tamper has no mask and always reaches the clock primary.
// RL15 - A primary is high while any of its status bits is set and unmasked.
// RL16 - Host software reads, handles, then writes ones to exactly the handled bits.
`timescale 1ns/1ps
module secondary_irq (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Avalon-MM slave
    input wire logic [irq_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [irq_pkg::DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [irq_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    // Event conditions
    input wire irq_pkg::events_s eventLevels,
    // Interrupts
    output irq_pkg::primary_s primaryIrq,
    output logic irqLine
);

    // ****************************************
    // Lane and decode helpers
    // ****************************************
    function automatic logic [15:0] laneMask(input logic [3:0] be);
        laneMask = {{8{be[1]}}, {8{be[0]}}};
    endfunction : laneMask

    function automatic logic [31:0] padWord(input logic [15:0] v);
        padWord = {irq_pkg::PAD_ZERO, v};
    endfunction : padWord

    logic [15:0] regIdx;
    logic hitStatus1, hitStatus4, hitMask1, hitMask4, hitCmpCfg;
    logic reqTake, wrTake, rdLoad;
    logic [15:0] lanes, wdLow;

    assign regIdx = address[17:2];
    assign hitStatus1 = regIdx == irq_pkg::STATUS1_IDX;
    assign hitStatus4 = regIdx == irq_pkg::STATUS4_IDX;
    assign hitMask1 = regIdx == irq_pkg::MASK1_IDX;
    assign hitMask4 = regIdx == irq_pkg::MASK4_IDX;
    assign hitCmpCfg = regIdx == irq_pkg::CMPCFG_IDX;
    // Request answered one cycle after it is first seen
    assign reqTake = (read || write) && !waitrequest;
    assign wrTake = write && !waitrequest;
    assign rdLoad = read && waitrequest;
    assign lanes = laneMask(byteenable);
    assign wdLow = writedata[15:0];

    // ****************************************
    // Event synchronisation
    // ****************************************
    logic [irq_pkg::EV_W-1:0] riseVec, fallVec;
    irq_pkg::events_s riseEv, fallEv;

    edge_sync u_edge_sync (
        .clock(clock),
        .arst_n(arst_n),
        .levelAsync(eventLevels),
        .rise(riseVec),
        .fall(fallVec)
    );

    assign riseEv = riseVec;
    assign fallEv = fallVec;

    // ****************************************
    // Comparator direction
    // ****************************************
    logic [3:0] cmpGt_r, cmpGt_nxt, cmpSet;

    // Greater-than picks the rising crossing, otherwise the falling one
    assign cmpSet = (cmpGt_r & riseEv.comparatorMatchEvents) | (~cmpGt_r & fallEv.comparatorMatchEvents); // RL9
    assign cmpGt_nxt = (wrTake && hitCmpCfg && byteenable[0]) ? writedata[3:0] : cmpGt_r;

    // ****************************************
    // Set and clear vectors
    // ****************************************
    logic [15:0] set1, set4, clr1, clr4;

    always_comb
    begin
        set1 = '0;
        set4 = '0;
        set1[irq_pkg::BIT_BUTTON] = riseEv.powerButtonEvent | fallEv.powerButtonEvent; // RL1
        set1[irq_pkg::BIT_TIMEOUT] = riseEv.timeoutGuardExpiredEvent; // RL7
        set1[irq_pkg::BIT_DATA_READY] = riseEv.auxConverterDataReadyEvent; // RL8
        set1[irq_pkg::BIT_CMP_LO +: irq_pkg::CMP_N] = cmpSet; // RL9
        set1[irq_pkg::BIT_SUPPLY_LOW] = riseEv.systemSupplyLowEvent; // RL10
        set1[irq_pkg::BIT_PERIODIC] = riseEv.calendarPeriodicEvent; // RL11
        set1[irq_pkg::BIT_ALARM] = riseEv.calendarAlarmEvent; // RL11
        set4[irq_pkg::BIT_XTAL_START] = riseEv.crystalStartFailEvent; // RL12
        set4[irq_pkg::BIT_TAMPER] = riseEv.crystalTamperEvent | fallEv.crystalTamperEvent; // RL13
    end

    // Only ones clear; zero lanes and zero bits keep their state
    assign clr1 = (wrTake && hitStatus1) ? (wdLow & lanes) : '0; // RL2
    assign clr4 = (wrTake && hitStatus4) ? (wdLow & lanes) : '0; // RL2

    // ****************************************
    // Status and mask banks
    // ****************************************
    logic [15:0] stat1, stat4, mask1, mask4, pend1, pend4;

    irq_bank #(
        .STATUS_IMPL(irq_pkg::STATUS1_IMPL),
        .MASK_IMPL(irq_pkg::MASK1_IMPL),
        .MASK_RST(irq_pkg::MASK1_RST)
    ) u_bank1 (
        .clock(clock),
        .arst_n(arst_n),
        .setBits(set1),
        .clrBits(clr1),
        .maskWe(wrTake && hitMask1),
        .maskLanes(lanes),
        .maskData(wdLow),
        .status_r(stat1),
        .mask_r(mask1),
        .pending(pend1)
    );

    // Tamper bit has no mask bit here, so it always passes
    irq_bank #(
        .STATUS_IMPL(irq_pkg::STATUS4_IMPL),
        .MASK_IMPL(irq_pkg::MASK4_IMPL),
        .MASK_RST(irq_pkg::MASK4_RST)
    ) u_bank4 (
        .clock(clock),
        .arst_n(arst_n),
        .setBits(set4),
        .clrBits(clr4),
        .maskWe(wrTake && hitMask4),
        .maskLanes(lanes),
        .maskData(wdLow),
        .status_r(stat4),
        .mask_r(mask4),
        .pending(pend4)
    );

    // ****************************************
    // Primary interrupts
    // ****************************************
    irq_pkg::primary_s primary_nxt;
    logic irq_nxt;

    assign primary_nxt.supplyPathPrimaryIrq = pend1[irq_pkg::BIT_SUPPLY_LOW]; // RL10
    assign primary_nxt.powerButtonPrimaryIrq = pend1[irq_pkg::BIT_BUTTON]; // RL3
    assign primary_nxt.timeoutGuardPrimaryIrq = pend1[irq_pkg::BIT_TIMEOUT]; // RL7
    assign primary_nxt.auxConverterPrimaryIrq = |pend1[irq_pkg::BIT_DATA_READY:irq_pkg::BIT_CMP_LO]; // RL8
    assign primary_nxt.calendarPrimaryIrq = pend1[irq_pkg::BIT_PERIODIC] | pend1[irq_pkg::BIT_ALARM]
        | pend4[irq_pkg::BIT_XTAL_START] | pend4[irq_pkg::BIT_TAMPER]; // RL14
    assign irq_nxt = |primary_nxt; // RL15

    // ****************************************
    // Read mux
    // ****************************************
    logic [31:0] rdMux;

    // Status reads ignore the mask, unmapped words read zero
    assign rdMux = hitStatus1 ? padWord(stat1) // RL4
        : hitStatus4 ? padWord(stat4)
        : hitMask1 ? padWord(mask1)
        : hitMask4 ? padWord(mask4)
        : hitCmpCfg ? padWord({12'h000, cmpGt_r})
        : '0;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            waitrequest <= 1'b1;
            readdata <= '0;
            cmpGt_r <= irq_pkg::CMPCFG_RST;
            primaryIrq <= '0;
            irqLine <= 1'b0;
        end
        else
        begin
            waitrequest <= !((read || write) && waitrequest);
            readdata <= rdLoad ? rdMux : readdata;
            cmpGt_r <= cmpGt_nxt;
            primaryIrq <= primary_nxt; // RL15
            irqLine <= irq_nxt;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    logic seenRst_r;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            seenRst_r <= 1'b0;
        else
            seenRst_r <= 1'b1;
    end

    sequence reqWaiting;
        (read || write) && waitrequest;
    endsequence

    sequence reqAnswered;
        !waitrequest ##1 waitrequest;
    endsequence

    sequence tamperSeen;
        riseEv.crystalTamperEvent || fallEv.crystalTamperEvent;
    endsequence

    a_bus_answer: assert property (reqWaiting |=> reqAnswered)
        else $error("bus request not answered in one cycle");

    a_button_edges: assert property ( // RL1
        (riseEv.powerButtonEvent || fallEv.powerButtonEvent) |=> stat1[irq_pkg::BIT_BUTTON])
        else $error("button edge did not set status");

    a_w1c_clear: assert property ( // RL2
        (wrTake && hitStatus1 && byteenable[1] && writedata[irq_pkg::BIT_TIMEOUT]
        && !set1[irq_pkg::BIT_TIMEOUT]) |=> !stat1[irq_pkg::BIT_TIMEOUT])
        else $error("write of one did not clear status");

    a_zero_keeps: assert property ( // RL2
        (wrTake && hitStatus1 && wdLow == '0) |=> ((stat1 & $past(stat1)) == $past(stat1)))
        else $error("write of zero cleared a status bit");

    a_mask_gates: assert property ( // RL3 RL5
        primaryIrq.timeoutGuardPrimaryIrq
        == ($past(stat1[irq_pkg::BIT_TIMEOUT]) && !$past(mask1[irq_pkg::BIT_TIMEOUT])))
        else $error("timeout primary disagrees with status and mask");

    a_status_unmasked: assert property ( // RL4 RL7
        (riseEv.timeoutGuardExpiredEvent && mask1[irq_pkg::BIT_TIMEOUT]) |=> stat1[irq_pkg::BIT_TIMEOUT])
        else $error("masked event not latched");

    a_mask_default: assert property ( // RL6
        !seenRst_r |-> (mask1 == irq_pkg::MASK1_RST && mask4 == irq_pkg::MASK4_RST))
        else $error("masks not set after reset");

    a_data_ready: assert property ( // RL8
        riseEv.auxConverterDataReadyEvent && !mask1[irq_pkg::BIT_DATA_READY]
        |=> stat1[irq_pkg::BIT_DATA_READY] ##1 primaryIrq.auxConverterPrimaryIrq)
        else $error("data ready did not reach its primary");

    a_cmp_direction: assert property ( // RL9
        (fallEv.comparatorMatchEvents[0] && !cmpGt_r[0]) |=> stat1[irq_pkg::BIT_CMP_LO])
        else $error("comparator falling trigger missed");

    a_supply_low: assert property ( // RL10
        riseEv.systemSupplyLowEvent |=> stat1[irq_pkg::BIT_SUPPLY_LOW])
        else $error("supply low not latched");

    a_calendar_bits: assert property ( // RL11
        riseEv.calendarAlarmEvent && !mask1[irq_pkg::BIT_ALARM]
        |=> stat1[irq_pkg::BIT_ALARM] ##1 primaryIrq.calendarPrimaryIrq)
        else $error("alarm did not reach clock primary");

    a_crystal_start: assert property ( // RL12
        (stat4[irq_pkg::BIT_XTAL_START] && mask4[irq_pkg::BIT_XTAL_START]
        && !stat4[irq_pkg::BIT_TAMPER] && !pend1[irq_pkg::BIT_PERIODIC] && !pend1[irq_pkg::BIT_ALARM])
        |=> !primaryIrq.calendarPrimaryIrq)
        else $error("masked crystal start raised clock primary");

    a_tamper_edges: assert property ( // RL13 RL14
        tamperSeen |=> stat4[irq_pkg::BIT_TAMPER] ##1 primaryIrq.calendarPrimaryIrq)
        else $error("tamper edge did not raise clock primary");

    a_line_follows: assert property ( // RL15
        irqLine == ($past(pend1) != '0 || $past(pend4) != '0))
        else $error("interrupt line disagrees with pending bits");

    sequence setThenRaise(statBit, primBit);
        statBit ##1 primBit;
    endsequence

    a_button_mask: assert property ( // RL3 RL5
        (stat1[irq_pkg::BIT_BUTTON] && mask1[irq_pkg::BIT_BUTTON]) |=> !primaryIrq.powerButtonPrimaryIrq)
        else $error("masked button raised its primary");

    a_button_raise: assert property ( // RL1 RL15
        (riseEv.powerButtonEvent || fallEv.powerButtonEvent) && !mask1[irq_pkg::BIT_BUTTON]
        |=> setThenRaise(stat1[irq_pkg::BIT_BUTTON], primaryIrq.powerButtonPrimaryIrq))
        else $error("button edge did not raise its primary");

    a_supply_mask: assert property ( // RL3 RL10
        (stat1[irq_pkg::BIT_SUPPLY_LOW] && mask1[irq_pkg::BIT_SUPPLY_LOW]) |=> !primaryIrq.supplyPathPrimaryIrq)
        else $error("masked supply low raised its primary");

    a_supply_raise: assert property ( // RL10 RL15
        riseEv.systemSupplyLowEvent && !mask1[irq_pkg::BIT_SUPPLY_LOW]
        |=> setThenRaise(stat1[irq_pkg::BIT_SUPPLY_LOW], primaryIrq.supplyPathPrimaryIrq))
        else $error("supply low did not raise its primary");

    a_timeout_raise: assert property ( // RL7
        riseEv.timeoutGuardExpiredEvent && !mask1[irq_pkg::BIT_TIMEOUT]
        |=> setThenRaise(stat1[irq_pkg::BIT_TIMEOUT], primaryIrq.timeoutGuardPrimaryIrq))
        else $error("timeout did not raise its primary");

    a_periodic_rise: assert property ( // RL11
        riseEv.calendarPeriodicEvent |=> stat1[irq_pkg::BIT_PERIODIC])
        else $error("periodic tick not latched");

    a_alarm_rise: assert property ( // RL11
        riseEv.calendarAlarmEvent |=> stat1[irq_pkg::BIT_ALARM])
        else $error("alarm not latched");

    a_start_rise: assert property ( // RL12
        riseEv.crystalStartFailEvent |=> stat4[irq_pkg::BIT_XTAL_START])
        else $error("crystal start failure not latched");

    a_tamper_passes: assert property ( // RL14
        stat4[irq_pkg::BIT_TAMPER] |=> primaryIrq.calendarPrimaryIrq)
        else $error("tamper status did not reach clock primary");

    a_cmp_rising: assert property ( // RL9
        (riseEv.comparatorMatchEvents[0] && cmpGt_r[0]) |=> stat1[irq_pkg::BIT_CMP_LO])
        else $error("comparator rising trigger missed");

    a_mask_write: assert property ( // RL5
        (wrTake && hitMask1 && (&byteenable[1:0])) |=> (mask1 == ($past(wdLow) & irq_pkg::MASK1_IMPL)))
        else $error("mask write did not land");

    a_aux_mask: assert property ( // RL3 RL15
        pend1[irq_pkg::BIT_DATA_READY:irq_pkg::BIT_CMP_LO] == '0 |=> !primaryIrq.auxConverterPrimaryIrq)
        else $error("converter primary high with nothing pending");

    a_w1c_group4: assert property ( // RL2
        (wrTake && hitStatus4 && byteenable[0] && writedata[irq_pkg::BIT_XTAL_START]
        && !set4[irq_pkg::BIT_XTAL_START]) |=> !stat4[irq_pkg::BIT_XTAL_START])
        else $error("write of one did not clear group 4 status");

endmodule : secondary_irq

/* File: logic/irq_pkg.sv */
// Shared constants and carrier types for the secondary interrupt block.
// Assumes a 32-bit register bus with byte addresses; a register index maps to byte address index*4.
package irq_pkg;

    // ****************************************
    // Register indices (byte address = index * 4)
    // ****************************************
    localparam logic [15:0] STATUS1_IDX = 16'h4011;
    localparam logic [15:0] STATUS4_IDX = 16'h4014;
    localparam logic [15:0] MASK1_IDX = 16'h4019;
    localparam logic [15:0] MASK4_IDX = 16'h401c;
    localparam logic [15:0] CMPCFG_IDX = 16'h4020;

    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int CMP_N = 4;
    localparam int EV_W = 12;

    // ****************************************
    // Bit positions
    // ****************************************
    localparam int BIT_SUPPLY_LOW = 15;
    localparam int BIT_BUTTON = 12;
    localparam int BIT_TIMEOUT = 11;
    localparam int BIT_DATA_READY = 8;
    localparam int BIT_CMP_LO = 4;
    localparam int BIT_PERIODIC = 3;
    localparam int BIT_ALARM = 2;
    localparam int BIT_XTAL_START = 7;
    localparam int BIT_TAMPER = 6;

    // ****************************************
    // Implemented bits and reset values
    // ****************************************
    localparam logic [15:0] STATUS1_IMPL = 16'h99fc;
    localparam logic [15:0] MASK1_IMPL = 16'h99fc;
    localparam logic [15:0] MASK1_RST = 16'h99fc;
    localparam logic [15:0] STATUS4_IMPL = 16'h00c0;
    localparam logic [15:0] MASK4_IMPL = 16'h0080;
    localparam logic [15:0] MASK4_RST = 16'h0080;
    localparam logic [3:0] CMPCFG_RST = 4'hf;
    localparam logic [15:0] PAD_ZERO = 16'h0000;

    // Event condition levels, as they arrive from the analogue side
    typedef struct packed {
        logic systemSupplyLowEvent;
        logic powerButtonEvent;
        logic timeoutGuardExpiredEvent;
        logic auxConverterDataReadyEvent;
        logic [3:0] comparatorMatchEvents;
        logic calendarPeriodicEvent;
        logic calendarAlarmEvent;
        logic crystalStartFailEvent;
        logic crystalTamperEvent;
    } events_s;

    typedef struct packed {
        logic supplyPathPrimaryIrq;
        logic powerButtonPrimaryIrq;
        logic timeoutGuardPrimaryIrq;
        logic auxConverterPrimaryIrq;
        logic calendarPrimaryIrq;
    } primary_s;

endpackage : irq_pkg

/* File: logic/edge_sync.sv */
// Three-stage synchroniser with agreement filter and edge pulses for all event inputs.
// Assumes asynchronous level inputs; pulses are one clock wide.
`timescale 1ns/1ps
module edge_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Levels in, edge pulses out
    input wire logic [irq_pkg::EV_W-1:0] levelAsync,
    output logic [irq_pkg::EV_W-1:0] rise,
    output logic [irq_pkg::EV_W-1:0] fall
);
    logic [irq_pkg::EV_W-1:0] s1_r, s2_r, s3_r, level_r;
    logic [irq_pkg::EV_W-1:0] agree;

    // A change counts only once stages two and three agree
    assign agree = ~(s2_r ^ s3_r);
    assign rise = agree & s3_r & ~level_r;
    assign fall = agree & ~s3_r & level_r;

    // Levels high at reset release show up as a rising edge
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            level_r <= '0;
        end
        else
        begin
            s1_r <= levelAsync;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= (agree & s3_r) | (~agree & level_r);
        end
    end
endmodule : edge_sync

/* File: logic/irq_bank.sv */
// One sticky status register with write-one-to-clear and its mask register.
// Assumes set and clear vectors arrive synchronous to clock.
`timescale 1ns/1ps
module irq_bank #(
    parameter logic [15:0] STATUS_IMPL = 16'h0000,
    parameter logic [15:0] MASK_IMPL = 16'h0000,
    parameter logic [15:0] MASK_RST = 16'h0000
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Events and software access
    input wire logic [15:0] setBits,
    input wire logic [15:0] clrBits,
    input wire logic maskWe,
    input wire logic [15:0] maskLanes,
    input wire logic [15:0] maskData,
    // State
    output logic [15:0] status_r,
    output logic [15:0] mask_r,
    output logic [15:0] pending
);
    logic [15:0] status_nxt, mask_nxt;

    // Set beats clear in the same cycle
    assign status_nxt = ((status_r & ~clrBits) | setBits) & STATUS_IMPL;
    assign mask_nxt = maskWe ? (((mask_r & ~maskLanes) | (maskData & maskLanes)) & MASK_IMPL) : mask_r;
    // Bits without a mask bit read mask 0, so they always pass
    assign pending = status_r & ~mask_r;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status_r <= '0;
            mask_r <= MASK_RST;
        end
        else
        begin
            status_r <= status_nxt;
            mask_r <= mask_nxt;
        end
    end
endmodule : irq_bank

/* File: tb/host_model.sv */
// Host processor model: Avalon-MM master and interrupt service routine.
// Assumes a slave that answers each request by pulling waitrequest low.
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire logic clock,
    // Avalon-MM master
    output logic [irq_pkg::ADDR_W-1:0] address,
    output logic read,
    output logic write,
    output logic [irq_pkg::DATA_W-1:0] writedata,
    output logic [3:0] byteenable,
    input wire logic [irq_pkg::DATA_W-1:0] readdata,
    input wire logic waitrequest
);
    initial
    begin
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        byteenable = 4'h0;
    end

    // ****************************************
    // Bus cycle
    // ****************************************
    // Request held until waitrequest is seen low; bounded so a dead slave cannot hang
    task automatic access(input logic isWr, input logic [15:0] idx, input logic [15:0] wData,
        input logic [3:0] be, output logic [15:0] rData, output logic ok);
        int n;
        ok = 1'b0;
        rData = 16'h0000;
        @(posedge clock);
        address <= {idx, 2'b00};
        read <= ~isWr;
        write <= isWr;
        writedata <= {16'h0000, wData};
        byteenable <= be;
        for (n = 0; n < 20 && !ok; n++)
        begin
            @(posedge clock);
            if (waitrequest === 1'b0)
            begin
                ok = 1'b1;
                rData = readdata[15:0];
            end
        end
        read <= 1'b0;
        write <= 1'b0;
    endtask : access

    // ****************************************
    // Service routine
    // ****************************************
    // Only bits both seen and handled are acknowledged
    task automatic service(input logic [15:0] idx, input logic [15:0] handle,
        output logic [15:0] seen, output logic ok);
        logic okRd;
        logic [15:0] dummy;
        access(1'b0, idx, 16'h0000, 4'hf, seen, okRd);
        access(1'b1, idx, seen & handle, 4'hf, dummy, ok);
        ok = ok & okRd;
    endtask : service
endmodule : host_model

/* File: tb/secondary_irq_tb.sv */
// Self-checking bench for the secondary interrupt block against a behavioural model.
// Assumes the host model drives the register bus; events are driven here.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin nCompared++; if ((got) !== (ex)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module secondary_irq_tb;
    logic clock;
    logic arst_n;
    logic [irq_pkg::ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [irq_pkg::DATA_W-1:0] writedata;
    logic [3:0] byteenable;
    logic [irq_pkg::DATA_W-1:0] readdata;
    logic waitrequest;
    irq_pkg::events_s eventLevels;
    irq_pkg::primary_s primaryIrq;
    logic irqLine;
    int miscompares;
    int nCompared;
    int seed;
    int i;
    logic [31:0] r;
    logic [15:0] rd;
    logic ok;
    logic [15:0] s1, s4, m1, m4, lanes;
    logic [3:0] cfg;
    logic [11:0] levelQ[$];

    secondary_irq dut_u (.clock(clock), .arst_n(arst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .eventLevels(eventLevels), .primaryIrq(primaryIrq), .irqLine(irqLine));
    host_model host_u (.clock(clock), .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));

    always #2.5 clock = ~clock;

    task automatic stopTest();
        $display("compared %0d mismatches %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stopTest

    task automatic bus(input logic isWr, input logic [15:0] idx, input logic [15:0] wd,
        input logic [3:0] be, output logic [15:0] data);
        logic okb;
        host_u.access(isWr, idx, wd, be, data, okb);
        if (okb !== 1'b1)
        begin
            miscompares++;
            $display("ERROR waitrequest expected 0 seen 1");
            stopTest();
        end
    endtask : bus

    // ****************************************
    // Reference model
    // ****************************************
    function automatic void applyEdges(input logic [11:0] o, input logic [11:0] n);
        logic [11:0] rs, fl;
        logic [3:0] c;
        rs = n & ~o;
        fl = o & ~n;
        c = (rs[7:4] & cfg) | (fl[7:4] & ~cfg);
        s1 = s1 | {rs[11], 2'b00, rs[10] | fl[10], rs[9], 2'b00, rs[8], c, rs[3], rs[2], 2'b00};
        s4 = s4 | {8'h00, rs[1], rs[0] | fl[0], 6'h00};
    endfunction : applyEdges

    function automatic logic [4:0] expPrim();
        logic [15:0] p1, p4;
        p1 = s1 & ~m1;
        p4 = s4 & ~m4;
        return {p1[15], p1[12], p1[11], |p1[8:4], |p1[3:2] | p4[7] | s4[6]};
    endfunction : expPrim

    // Levels held 8 cycles so the synchroniser sees a clean edge
    task automatic setLevels(input logic [11:0] n);
        @(posedge clock);
        eventLevels <= irq_pkg::events_s'(n);
        applyEdges(levelQ[$], n);
        levelQ.push_back(n);
        repeat (8) @(posedge clock);
    endtask : setLevels

    task automatic checkAll();
        logic [15:0] d;
        repeat (2) @(posedge clock);
        `CHK("primaryIrq", expPrim(), primaryIrq)
        `CHK("irqLine", |expPrim(), irqLine)
        bus(1'b0, irq_pkg::STATUS1_IDX, 16'h0000, 4'hf, d);
        `CHK("status1", s1, d)
        bus(1'b0, irq_pkg::STATUS4_IDX, 16'h0000, 4'hf, d);
        `CHK("status4", s4, d)
        bus(1'b0, irq_pkg::MASK1_IDX, 16'h0000, 4'hf, d);
        `CHK("mask1", m1, d)
        bus(1'b0, irq_pkg::MASK4_IDX, 16'h0000, 4'hf, d);
        `CHK("mask4", m4, d)
    endtask : checkAll

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        clock = 1'b0;
        arst_n = 1'b0;
        eventLevels = '0;
        seed = 35134;
        miscompares = 0;
        nCompared = 0;
        s1 = 16'h0000;
        s4 = 16'h0000;
        m1 = irq_pkg::MASK1_RST;
        m4 = irq_pkg::MASK4_RST;
        cfg = 4'hf;
        levelQ.push_back(12'h000);
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        bus(1'b0, irq_pkg::MASK1_IDX, 16'h0000, 4'hf, rd);
        `CHK("mask1", 16'h99fc, rd)
        bus(1'b0, irq_pkg::MASK4_IDX, 16'h0000, 4'hf, rd);
        `CHK("mask4", 16'h0080, rd)
        bus(1'b0, irq_pkg::CMPCFG_IDX, 16'h0000, 4'hf, rd);
        `CHK("cmpcfg", 16'h000f, rd)
        bus(1'b0, 16'h4015, 16'h0000, 4'hf, rd);
        `CHK("unmapped", 16'h0000, rd)
        checkAll();
        $display("test reset done");
        // Tamper alone must reach the clock primary with every mask still set
        setLevels(12'h001);
        checkAll();
        `CHK("calendarIrq", 1'b1, primaryIrq.calendarPrimaryIrq)
        $display("test tamper done");
        for (i = 0; i < 80; i++)
        begin
            r = $random(seed);
            lanes = {{8{r[5]}}, {8{r[4]}}};
            case (r[1:0])
                2'd0: setLevels(r[27:16]);
                2'd1:
                begin
                    bus(1'b1, r[2] ? irq_pkg::MASK4_IDX : irq_pkg::MASK1_IDX, r[31:16], {2'b00, r[5:4]}, rd);
                    if (r[2])
                        m4 = (m4 & ~lanes) | (r[31:16] & lanes & irq_pkg::MASK4_IMPL);
                    else
                        m1 = (m1 & ~lanes) | (r[31:16] & lanes & irq_pkg::MASK1_IMPL);
                end
                2'd2:
                begin
                    bus(1'b1, irq_pkg::CMPCFG_IDX, {12'h000, r[19:16]}, 4'hf, rd);
                    cfg = r[19:16];
                end
                default:
                begin
                    host_u.service(r[2] ? irq_pkg::STATUS4_IDX : irq_pkg::STATUS1_IDX, r[31:16], rd, ok);
                    `CHK("serviceRead", r[2] ? s4 : s1, rd)
                    if (ok !== 1'b1)
                    begin
                        miscompares++;
                        $display("ERROR waitrequest expected 0 seen 1");
                        stopTest();
                    end
                    if (r[2])
                        s4 = s4 & ~r[31:16];
                    else
                        s1 = s1 & ~r[31:16];
                end
            endcase
            checkAll();
        end
        $display("test random done");
        stopTest();
    end
endmodule : secondary_irq_tb
